// [logic/modbus_map_bank.sv]
`timescale 1ns/100ps
`default_nettype none
// How it works
// - mapped regions serve function codes 03, 06 and 16 with matching reads or writes.
// - 16-bit region has 128 one-address entries at 20000 to 20127.
// - 16-bit entries are presented high byte first, then low byte.
// - 32-bit region has 64 two-address entries from 20128, last at 20254.
// - 32-bit entries are stored most significant byte first, lowest address upward.
// - 64-bit region has 64 four-address entries from 20256, last at 20508.
// - 64-bit entries are stored with eight bytes most significant first.
// - each entry may come from a downstream input or holding register.
// - mid variant keeps 20000 to 20127; smallest variant keeps 20000 to 20063.
// - mid variant has a 32-bit region ending at 20190; smallest has none.
// - only the full variant has a 64-bit region.
// - variants differ only in mapped register count.
// - mapping end address is derived from start address plus read quantity.
// - mapped address access corresponds to the downstream register, offset by start addresses.
// - at most 16 downstream slaves feed the mapping.
module modbus_map_bank
  import map_bank_pkg::*;
#(
  parameter variant_t VARIANT = VARIANT_FULL
) (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // upstream request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [7:0] req_func,
  input wire logic [15:0] req_addr,
  input wire logic [7:0] req_qty,
  // upstream write data words
  input wire logic wr_valid,
  output logic wr_ready,
  input wire logic [15:0] wr_word,
  // upstream answer
  output logic rsp_valid,
  output logic [15:0] rsp_word,
  output logic rsp_done,
  output logic [7:0] rsp_exc,
  // polled entry store
  input wire logic poll_valid,
  output logic poll_ready,
  input wire logic [15:0] poll_addr,
  input wire logic [2:0] poll_words,
  input wire logic [63:0] poll_data,
  // mapping configuration
  input wire logic cfg_we,
  input wire logic [SLAVE_IW-1:0] cfg_idx,
  input wire logic [15:0] cfg_map_start,
  input wire logic [7:0] cfg_qty,
  input wire logic [15:0] cfg_slave_start,
  input wire logic cfg_from_holding,
  input wire logic [SLAVE_IW-1:0] cfg_rd_idx,
  output logic [15:0] cfg_map_end,
  // downstream write request
  output logic ds_wr_valid,
  output logic [SLAVE_IW-1:0] ds_slave_idx,
  output logic [15:0] ds_reg_addr,
  output logic [15:0] ds_wr_data
);

  logic rst_meta_reg;
  logic rst_n;
  state_t state_reg, state_next;
  logic [7:0] func_reg, func_next;
  logic [15:0] addr_reg, addr_next;
  logic [7:0] qty_reg, qty_next;
  logic [7:0] left_reg, left_next;
  logic [7:0] exc_reg, exc_next;
  logic rd_pend_reg, rd_pend_next;
  logic [63:0] pdata_reg, pdata_next;
  logic mem_we, mem_re;
  logic [MAP_AW-1:0] mem_waddr, mem_raddr;
  logic [15:0] mem_wdata;
  logic [16:0] req_off, req_span;
  logic [15:0] map_start [MAX_SLAVES];
  logic [7:0] map_qty [MAX_SLAVES];
  logic [15:0] slave_start [MAX_SLAVES];
  logic from_holding [MAX_SLAVES];
  logic [MAX_SLAVES-1:0] hit;
  logic hit_any;
  logic [SLAVE_IW-1:0] hit_idx;
  logic [15:0] cfg_map_end_next;
  logic ds_wr_valid_next;
  logic [SLAVE_IW-1:0] ds_slave_idx_next;
  logic [15:0] ds_reg_addr_next, ds_wr_data_next;
  logic wr_fire;

  // reset release through two flops, assertion stays asynchronous
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta_reg <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n <= rst_meta_reg;
    end
  end

  // mapping table, one entry per downstream slave
  for (genvar i = 0; i < MAX_SLAVES; i++) begin : g_map
    logic [15:0] start_next, sstart_next;
    logic [7:0] qty_e_next;
    logic hold_next;
    logic [16:0] rel;
    always_comb begin
      start_next = map_start[i];
      qty_e_next = map_qty[i];
      sstart_next = slave_start[i];
      hold_next = from_holding[i];
      if (cfg_we && cfg_idx == SLAVE_IW'(i)) begin
        start_next = cfg_map_start;
        qty_e_next = cfg_qty;
        sstart_next = cfg_slave_start;
        hold_next = cfg_from_holding;
      end
      rel = {1'b0, addr_reg} - {1'b0, map_start[i]};
      hit[i] = !rel[16] && rel[15:0] < {8'h00, map_qty[i]};
    end
    always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
        map_start[i] <= '0;
        map_qty[i] <= '0;
        slave_start[i] <= '0;
        from_holding[i] <= 1'b0;
      end else begin
        map_start[i] <= start_next;
        map_qty[i] <= qty_e_next;
        slave_start[i] <= sstart_next;
        from_holding[i] <= hold_next;
      end
    end
  end

  // lowest configured entry wins when mappings overlap
  always_comb begin
    hit_any = 1'b0;
    hit_idx = '0;
    for (int i = MAX_SLAVES - 1; i >= 0; i--) begin
      if (hit[i]) begin
        hit_any = 1'b1;
        hit_idx = SLAVE_IW'(i);
      end
    end
  end

  assign req_ready = state_reg == ST_IDLE;
  assign poll_ready = state_reg == ST_IDLE && !req_valid;
  assign wr_ready = state_reg == ST_WRITE;
  assign wr_fire = wr_valid && wr_ready;
  assign rsp_done = state_reg == ST_DONE;
  assign rsp_valid = rd_pend_reg;
  assign rsp_exc = exc_reg;
  assign req_off = {1'b0, req_addr} - {1'b0, MAPPED_WORD_FIRST};
  assign req_span = {1'b0, addr_reg} - {1'b0, MAPPED_WORD_FIRST} + {9'h000, qty_reg};

  // request sequencer
  always_comb begin
    state_next = state_reg;
    func_next = func_reg;
    addr_next = addr_reg;
    qty_next = qty_reg;
    left_next = left_reg;
    exc_next = exc_reg;
    pdata_next = pdata_reg;
    rd_pend_next = 1'b0;
    mem_we = 1'b0;
    mem_re = 1'b0;
    mem_waddr = MAP_AW'(addr_reg - MAPPED_WORD_FIRST);
    mem_raddr = MAP_AW'(addr_reg - MAPPED_WORD_FIRST);
    mem_wdata = wr_word;
    case (state_reg)
      ST_IDLE: begin
        if (req_valid) begin
          func_next = req_func;
          addr_next = req_addr;
          qty_next = req_func == FC_WRITE_SINGLE ? 8'h01 : req_qty;
          left_next = req_func == FC_WRITE_SINGLE ? 8'h01 : req_qty;
          exc_next = EXC_NONE;
          state_next = ST_CHECK;
        end else if (poll_valid) begin
          addr_next = poll_addr;
          left_next = {5'h00, poll_words};
          // left-align so the top word always leaves first
          case (poll_words)
            POLL_WORDS_16: pdata_next = {poll_data[15:0], 48'h0};
            POLL_WORDS_32: pdata_next = {poll_data[31:0], 32'h0};
            default: pdata_next = poll_data;
          endcase
          state_next = ST_POLL;
        end
      end
      ST_CHECK: begin
        if (func_reg != FC_READ_HOLDING && func_reg != FC_WRITE_SINGLE
            && func_reg != FC_WRITE_MULTI) begin
          exc_next = EXC_ILLEGAL_FUNC;
          state_next = ST_DONE;
        end else if (qty_reg == 8'h00
                     || (func_reg == FC_READ_HOLDING && qty_reg > MAX_READ_QTY)
                     || (func_reg == FC_WRITE_MULTI && qty_reg > MAX_WRITE_QTY)) begin
          exc_next = EXC_ILLEGAL_VALUE;
          state_next = ST_DONE;
        end else if (addr_reg < MAPPED_WORD_FIRST || req_span > mapped_words(VARIANT)) begin
          exc_next = EXC_ILLEGAL_ADDR;
          state_next = ST_DONE;
        end else if (func_reg == FC_READ_HOLDING) begin
          state_next = ST_READ;
        end else begin
          state_next = ST_WRITE;
        end
      end
      ST_READ: begin
        mem_re = 1'b1;
        rd_pend_next = 1'b1;
        addr_next = addr_reg + 16'h0001;
        left_next = left_reg - 8'h01;
        if (left_reg == 8'h01) begin
          state_next = ST_DONE;
        end
      end
      ST_WRITE: begin
        if (wr_valid) begin
          mem_we = 1'b1;
          addr_next = addr_reg + 16'h0001;
          left_next = left_reg - 8'h01;
          if (left_reg == 8'h01) begin
            state_next = ST_DONE;
          end
        end
      end
      ST_POLL: begin
        // an entry that falls outside this variant's map is dropped
        mem_we = addr_reg >= MAPPED_WORD_FIRST
                 && ({1'b0, addr_reg} - {1'b0, MAPPED_WORD_FIRST}) < mapped_words(VARIANT);
        mem_wdata = pdata_reg[63:48];
        pdata_next = {pdata_reg[47:0], 16'h0000};
        addr_next = addr_reg + 16'h0001;
        left_next = left_reg - 8'h01;
        if (left_reg <= 8'h01) begin
          state_next = ST_IDLE;
        end
      end
      ST_DONE: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_IDLE;
      func_reg <= '0;
      addr_reg <= '0;
      qty_reg <= '0;
      left_reg <= '0;
      exc_reg <= EXC_NONE;
      rd_pend_reg <= 1'b0;
      pdata_reg <= '0;
    end else begin
      state_reg <= state_next;
      func_reg <= func_next;
      addr_reg <= addr_next;
      qty_reg <= qty_next;
      left_reg <= left_next;
      exc_reg <= exc_next;
      rd_pend_reg <= rd_pend_next;
      pdata_reg <= pdata_next;
    end
  end

  // word storage; each address keeps high byte in [15:8]
  map_word_mem #(
    .WIDTH(16),
    .DEPTH(MAP_DEPTH),
    .AW(MAP_AW)
  ) u_mem (
    .clk(clk),
    .rst_n(rst_n),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .re(mem_re),
    .raddr(mem_raddr),
    .rdata(rsp_word)
  );

  // host writes to a holding-sourced entry are forwarded downstream
  always_comb begin
    ds_wr_valid_next = 1'b0;
    ds_slave_idx_next = ds_slave_idx;
    ds_reg_addr_next = ds_reg_addr;
    ds_wr_data_next = ds_wr_data;
    if (wr_fire && hit_any && from_holding[hit_idx]) begin
      ds_wr_valid_next = 1'b1;
      ds_slave_idx_next = hit_idx;
      ds_reg_addr_next = slave_start[hit_idx] + (addr_reg - map_start[hit_idx]);
      ds_wr_data_next = wr_word;
    end
    if (map_qty[cfg_rd_idx] == 8'h00) begin
      cfg_map_end_next = map_start[cfg_rd_idx];
    end else begin
      cfg_map_end_next = map_start[cfg_rd_idx] + {8'h00, map_qty[cfg_rd_idx]} - 16'h0001;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ds_wr_valid <= 1'b0;
      ds_slave_idx <= '0;
      ds_reg_addr <= '0;
      ds_wr_data <= '0;
      cfg_map_end <= '0;
    end else begin
      ds_wr_valid <= ds_wr_valid_next;
      ds_slave_idx <= ds_slave_idx_next;
      ds_reg_addr <= ds_reg_addr_next;
      ds_wr_data <= ds_wr_data_next;
      cfg_map_end <= cfg_map_end_next;
    end
  end

  // checks
  logic [7:0] rv_cnt_reg;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rv_cnt_reg <= '0;
    end else if (state_reg == ST_IDLE) begin
      rv_cnt_reg <= '0;
    end else if (rsp_valid) begin
      rv_cnt_reg <= rv_cnt_reg + 8'h01;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  read_count_a: assert property (rsp_done && exc_reg == EXC_NONE
    && func_reg == FC_READ_HOLDING
    |-> rv_cnt_reg + 8'(rsp_valid) == qty_reg) else $error("read word count wrong");
  low_addr_a: assert property (req_valid && req_ready && req_func == FC_READ_HOLDING
    && req_qty == 8'h01 && req_addr < MAPPED_WORD_FIRST
    |-> ##2 rsp_done && rsp_exc == EXC_ILLEGAL_ADDR) else $error("low address accepted");
  top_addr_a: assert property (req_valid && req_ready && req_func == FC_READ_HOLDING
    && req_qty == 8'h01 && req_addr >= MAPPED_WORD_FIRST
    && {1'b0, req_addr} - {1'b0, MAPPED_WORD_FIRST} >= mapped_words(VARIANT)
    |-> ##2 rsp_done && rsp_exc == EXC_ILLEGAL_ADDR) else $error("unmapped address ok");
  word_order_a: assert property (poll_valid && poll_ready
    && poll_words == POLL_WORDS_16
    |=> mem_wdata == $past(poll_data[15:0])) else $error("16-bit word wrong");
  dword_order_a: assert property (poll_valid && poll_ready
    && poll_words == POLL_WORDS_32
    |=> mem_wdata == $past(poll_data[31:16]) ##1 mem_wdata == $past(poll_data[15:0], 2))
    else $error("32-bit order wrong");
  qword_order_a: assert property (poll_valid && poll_ready
    && poll_words == POLL_WORDS_64
    |=> mem_wdata == $past(poll_data[63:48]) ##3 mem_wdata == $past(poll_data[15:0], 4))
    else $error("64-bit order wrong");
  forward_a: assert property (wr_fire && hit_any && from_holding[hit_idx]
    |=> ds_wr_valid && ds_wr_data == $past(wr_word)) else $error("write not forwarded");
  input_src_a: assert property (wr_fire && !(hit_any && from_holding[hit_idx])
    |=> !ds_wr_valid) else $error("input entry forwarded");
  map_end_a: assert property (cfg_we && cfg_idx == cfg_rd_idx && cfg_qty != 8'h00
    ##1 $stable(cfg_rd_idx) |=> cfg_map_end == $past(cfg_map_start, 2)
    + {8'h00, $past(cfg_qty, 2)} - 16'h0001) else $error("end address not updated");
  end_calc_a: assert property (map_qty[cfg_rd_idx] != 8'h00 |=> cfg_map_end
    == $past(map_start[cfg_rd_idx]) + {8'h00, $past(map_qty[cfg_rd_idx])} - 16'h0001)
    else $error("end address wrong");

  read_ok_c: cover property (rsp_done && exc_reg == EXC_NONE && func_reg == FC_READ_HOLDING);
  write_multi_c: cover property (rsp_done && exc_reg == EXC_NONE && func_reg == FC_WRITE_MULTI);
  poll_qword_c: cover property (poll_valid && poll_ready && poll_words == POLL_WORDS_64);
  exc_addr_c: cover property (rsp_done && rsp_exc == EXC_ILLEGAL_ADDR);

endmodule
`default_nettype wire

// [inc/map_bank_pkg.sv]
package map_bank_pkg;

  // function codes and exception codes of the upstream protocol
  localparam logic [7:0] FC_READ_HOLDING = 8'h03;
  localparam logic [7:0] FC_WRITE_SINGLE = 8'h06;
  localparam logic [7:0] FC_WRITE_MULTI = 8'h10;
  localparam logic [7:0] EXC_NONE = 8'h00;
  localparam logic [7:0] EXC_ILLEGAL_FUNC = 8'h01;
  localparam logic [7:0] EXC_ILLEGAL_ADDR = 8'h02;
  localparam logic [7:0] EXC_ILLEGAL_VALUE = 8'h03;
  localparam logic [7:0] MAX_READ_QTY = 8'h7d;
  localparam logic [7:0] MAX_WRITE_QTY = 8'h7b;

  // mapped holding-register map (decimal 20000 .. 20511)
  localparam logic [15:0] MAPPED_WORD_FIRST = 16'h4e20;
  localparam logic [15:0] MAPPED_WORD_SECOND = 16'h4e21;
  localparam logic [15:0] MAPPED_WORD_THIRD = 16'h4e22;
  localparam logic [15:0] MAPPED_WORD_LAST = 16'h4e9f;
  localparam logic [15:0] MAPPED_DWORD_FIRST = 16'h4ea0;
  localparam logic [15:0] MAPPED_DWORD_SECOND = 16'h4ea2;
  localparam logic [15:0] MAPPED_DWORD_THIRD = 16'h4ea4;
  localparam logic [15:0] MAPPED_DWORD_LAST = 16'h4f1e;
  localparam logic [15:0] MAPPED_QWORD_FIRST = 16'h4f20;
  localparam logic [15:0] MAPPED_QWORD_SECOND = 16'h4f24;
  localparam logic [15:0] MAPPED_QWORD_THIRD = 16'h4f28;
  localparam logic [15:0] MAPPED_QWORD_LAST = 16'h501c;

  // entry counts per region and words per entry
  localparam int WORD_ENTRIES_FULL = 128;
  localparam int WORD_ENTRIES_SMALL = 64;
  localparam int DWORD_ENTRIES_FULL = 64;
  localparam int DWORD_ENTRIES_MID = 32;
  localparam int QWORD_ENTRIES_FULL = 64;
  localparam int WORDS_PER_DWORD = 2;
  localparam int WORDS_PER_QWORD = 4;
  localparam int MAP_DEPTH = WORD_ENTRIES_FULL + WORDS_PER_DWORD * DWORD_ENTRIES_FULL
                             + WORDS_PER_QWORD * QWORD_ENTRIES_FULL;
  localparam int MAP_AW = 9;
  localparam int MAX_SLAVES = 16;
  localparam int SLAVE_IW = 4;

  // poll entry widths in words
  localparam logic [2:0] POLL_WORDS_16 = 3'h1;
  localparam logic [2:0] POLL_WORDS_32 = 3'h2;
  localparam logic [2:0] POLL_WORDS_64 = 3'h4;

  typedef enum logic [1:0] {
    VARIANT_FULL = 2'h0,
    VARIANT_MID = 2'h1,
    VARIANT_SMALL = 2'h2
  } variant_t;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_CHECK = 6'h02,
    ST_READ = 6'h04,
    ST_WRITE = 6'h08,
    ST_POLL = 6'h10,
    ST_DONE = 6'h20
  } state_t;

  // number of implemented mapped words above MAPPED_WORD_FIRST
  function automatic logic [16:0] mapped_words(input variant_t v);
    case (v)
      VARIANT_MID: mapped_words = 17'(WORD_ENTRIES_FULL + WORDS_PER_DWORD * DWORD_ENTRIES_MID);
      VARIANT_SMALL: mapped_words = 17'(WORD_ENTRIES_SMALL);
      default: mapped_words = 17'(MAP_DEPTH);
    endcase
  endfunction

endpackage

// [logic/map_word_mem.sv]
`timescale 1ns/100ps
`default_nettype none
module map_word_mem #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // write port
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [WIDTH-1:0] wdata,
  // read port, data one cycle after re
  input wire logic re,
  input wire logic [AW-1:0] raddr,
  output logic [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [WIDTH-1:0] rdata_next;

  // array has no reset: mapped values are unknown until the poller or a host write fills them
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  always_comb begin
    rdata_next = rdata;
    if (re) begin
      rdata_next = mem[raddr];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata <= '0;
    end else begin
      rdata <= rdata_next;
    end
  end

endmodule
`default_nettype wire

// [sim/upstream_host.sv]
`timescale 1ns/100ps
`default_nettype none
module upstream_host (
  // clock
  input wire logic clk,
  // request to the bank
  output logic req_valid,
  input wire logic req_ready,
  output logic [7:0] req_func,
  output logic [15:0] req_addr,
  output logic [7:0] req_qty,
  // write data words
  output logic wr_valid,
  input wire logic wr_ready,
  output logic [15:0] wr_word
);
  initial begin
    req_valid = 1'b0;
    req_func = 8'h00;
    req_addr = 16'h0000;
    req_qty = 8'h00;
    wr_valid = 1'b0;
    wr_word = 16'h0000;
  end
  // slave identifier is resolved by the front end before anything reaches here
  task automatic send_req(input logic [7:0] f, input logic [15:0] a, input logic [7:0] q);
    int n;
    @(negedge clk);
    req_func = f;
    req_addr = a;
    req_qty = q;
    req_valid = 1'b1;
    for (n = 0; n < 200 && req_ready !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    // released address and quantity lines show garbage, not the old value
    req_addr = ~a;
    req_qty = ~q;
  endtask
  task automatic send_word(input logic [15:0] w);
    int n;
    wr_word = w;
    wr_valid = 1'b1;
    for (n = 0; n < 200 && wr_ready !== 1'b1; n++) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
  endtask
  task automatic end_words;
    wr_valid = 1'b0;
    wr_word = ~wr_word;
  endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
`timescale 1ns/100ps
`default_nettype none
module tb;
  import map_bank_pkg::*;
  logic clk, nrst, req_valid, req_ready, wr_valid, wr_ready, rsp_valid, rsp_done;
  logic poll_valid, poll_ready, cfg_we, cfg_from_holding, ds_wr_valid;
  logic [7:0] req_func, req_qty, rsp_exc, cfg_qty;
  logic [15:0] req_addr, wr_word, rsp_word, poll_addr, cfg_map_start, cfg_slave_start;
  logic [15:0] cfg_map_end, ds_reg_addr, ds_wr_data;
  logic [2:0] poll_words;
  logic [63:0] poll_data;
  logic [SLAVE_IW-1:0] cfg_idx, cfg_rd_idx, ds_slave_idx;
  logic [15:0] mem [int];
  logic [15:0] exp_word [$];
  logic [7:0] exp_exc [$];
  logic [35:0] exp_ds [$];
  int mismatches, checks_done, cycles, seed, k;

  modbus_map_bank uut (
    .clk(clk), .nrst(nrst), .req_valid(req_valid), .req_ready(req_ready),
    .req_func(req_func), .req_addr(req_addr), .req_qty(req_qty),
    .wr_valid(wr_valid), .wr_ready(wr_ready), .wr_word(wr_word),
    .rsp_valid(rsp_valid), .rsp_word(rsp_word), .rsp_done(rsp_done), .rsp_exc(rsp_exc),
    .poll_valid(poll_valid), .poll_ready(poll_ready), .poll_addr(poll_addr),
    .poll_words(poll_words), .poll_data(poll_data), .cfg_we(cfg_we), .cfg_idx(cfg_idx),
    .cfg_map_start(cfg_map_start), .cfg_qty(cfg_qty), .cfg_slave_start(cfg_slave_start),
    .cfg_from_holding(cfg_from_holding), .cfg_rd_idx(cfg_rd_idx),
    .cfg_map_end(cfg_map_end), .ds_wr_valid(ds_wr_valid), .ds_slave_idx(ds_slave_idx),
    .ds_reg_addr(ds_reg_addr), .ds_wr_data(ds_wr_data)
  );
  upstream_host h (
    .clk(clk), .req_valid(req_valid), .req_ready(req_ready), .req_func(req_func),
    .req_addr(req_addr), .req_qty(req_qty), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_word(wr_word)
  );

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input logic [35:0] got, input logic [35:0] exp);
    checks_done++;
    if (got !== exp || $isunknown(got)) begin
      mismatches++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    chk(36'(got), 36'(exp));
  endtask

  task automatic chk_exc(input logic [7:0] got, input logic [7:0] exp);
    chk(36'(got), 36'(exp));
  endtask

  task automatic chk_end(input logic [15:0] got, input logic [15:0] exp);
    chk(36'(got), 36'(exp));
  endtask

  task automatic print_verdict;
    if (mismatches == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic cfg(input logic [3:0] i, input logic [15:0] s, input logic [7:0] q,
                     input logic [15:0] ss, input logic hold);
    cfg_idx = i;
    cfg_rd_idx = i;
    cfg_map_start = s;
    cfg_qty = q;
    cfg_slave_start = ss;
    cfg_from_holding = hold;
    cfg_we = 1'b1;
    @(negedge clk);
    cfg_we = 1'b0;
    repeat (2) @(negedge clk);
    chk_end(cfg_map_end, s + {8'h00, q} - 16'h0001);
  endtask

  // expected words are split most significant word first at the entry address
  task automatic poll(input logic [15:0] a, input logic [2:0] n);
    logic [63:0] d;
    int j;
    // one idle edge so poll_valid is never lowered and raised in one time step
    @(negedge clk);
    d = {$random(seed), $random(seed)};
    for (j = 0; j < n; j++) mem[a + j] = d[16 * (n - 1 - j) +: 16];
    poll_addr = a;
    poll_words = n;
    poll_data = d;
    poll_valid = 1'b1;
    for (j = 0; j < 200 && poll_ready !== 1'b1; j++) @(negedge clk);
    @(posedge clk);
    @(negedge clk);
    poll_valid = 1'b0;
    poll_data = ~d;
    poll_addr = ~a;
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] q);
    int j;
    for (j = 0; j < q; j++) exp_word.push_back(mem[a + j]);
    exp_exc.push_back(EXC_NONE);
    h.send_req(FC_READ_HOLDING, a, q);
  endtask

  // entry 0 maps 20000..20003 onto holding registers from 100 of slave 0
  task automatic wr(input logic [7:0] f, input logic [15:0] a, input int n);
    logic [15:0] w [$];
    int j;
    for (j = 0; j < n; j++) begin
      w.push_back(16'($random(seed)));
      mem[a + j] = w[j];
      if (a + j < MAPPED_WORD_FIRST + 4) begin
        exp_ds.push_back({4'h0, 16'(16'h0064 + a + j - MAPPED_WORD_FIRST), w[j]});
      end
    end
    exp_exc.push_back(EXC_NONE);
    h.send_req(f, a, 8'(n));
    for (j = 0; j < n; j++) h.send_word(w[j]);
    h.end_words();
  endtask

  task automatic ex(input logic [7:0] f, input logic [15:0] a, input logic [7:0] q,
                    input logic [7:0] e);
    exp_exc.push_back(e);
    h.send_req(f, a, q);
  endtask

  always @(negedge clk) begin
    if (rsp_valid === 1'b1) begin
      chk_word(rsp_word, exp_word.size() > 0 ? exp_word.pop_front()
               : 16'hxxxx);
    end
    if (rsp_done === 1'b1) begin
      chk_exc(rsp_exc, exp_exc.size() > 0 ? exp_exc.pop_front() : 8'hxx);
    end
    if (ds_wr_valid === 1'b1) begin
      chk({ds_slave_idx, ds_reg_addr, ds_wr_data},
          exp_ds.size() > 0 ? exp_ds.pop_front() : 'x);
    end
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    seed = 5;
    nrst = 1'b0;
    poll_valid = 1'b0;
    poll_addr = 16'h0000;
    poll_words = 3'h0;
    poll_data = 64'h0;
    cfg_we = 1'b0;
    cfg_idx = 4'h0;
    cfg_rd_idx = 4'h0;
    cfg_map_start = 16'h0000;
    cfg_qty = 8'h00;
    cfg_slave_start = 16'h0000;
    cfg_from_holding = 1'b0;
    repeat (16) @(negedge clk);
    nrst = 1'b1;
    repeat (3) @(negedge clk);
    cfg(4'h0, MAPPED_WORD_FIRST, 8'h04, 16'h0064, 1'b1);
    cfg(4'h1, MAPPED_DWORD_FIRST, 8'h02, 16'h0006, 1'b0);
    for (k = 0; k < 4; k++) poll(MAPPED_WORD_FIRST + 16'(k), POLL_WORDS_16);
    poll(MAPPED_WORD_LAST, POLL_WORDS_16);
    poll(MAPPED_DWORD_FIRST, POLL_WORDS_32);
    poll(MAPPED_DWORD_LAST, POLL_WORDS_32);
    poll(MAPPED_QWORD_FIRST, POLL_WORDS_64);
    poll(MAPPED_QWORD_LAST, POLL_WORDS_64);
    rd(MAPPED_WORD_FIRST, 8'h04);
    rd(MAPPED_WORD_LAST, 8'h03);
    rd(MAPPED_DWORD_LAST, 8'h02);
    rd(MAPPED_QWORD_FIRST, 8'h04);
    rd(MAPPED_QWORD_LAST, 8'h04);
    wr(FC_WRITE_SINGLE, MAPPED_WORD_SECOND, 1);
    // straddles the end of entry 0: the last word stays local
    wr(FC_WRITE_MULTI, MAPPED_WORD_THIRD, 3);
    wr(FC_WRITE_MULTI, MAPPED_DWORD_FIRST, 2);
    rd(MAPPED_WORD_FIRST, 8'h05);
    rd(MAPPED_DWORD_FIRST, 8'h02);
    ex(8'h04, MAPPED_WORD_FIRST, 8'h01, EXC_ILLEGAL_FUNC);
    ex(FC_READ_HOLDING, MAPPED_WORD_FIRST, 8'h00, EXC_ILLEGAL_VALUE);
    ex(FC_READ_HOLDING, MAPPED_WORD_FIRST, MAX_READ_QTY + 8'h01, EXC_ILLEGAL_VALUE);
    ex(FC_WRITE_MULTI, MAPPED_WORD_FIRST, MAX_WRITE_QTY + 8'h01, EXC_ILLEGAL_VALUE);
    ex(FC_READ_HOLDING, MAPPED_WORD_FIRST - 16'h0001, 8'h01, EXC_ILLEGAL_ADDR);
    ex(FC_READ_HOLDING, MAPPED_QWORD_LAST + 16'h0002, 8'h03, EXC_ILLEGAL_ADDR);
    ex(FC_WRITE_SINGLE, MAPPED_QWORD_LAST + 16'h0004, 8'h01, EXC_ILLEGAL_ADDR);
    // single-word read just past the top of the map
    ex(FC_READ_HOLDING, MAPPED_QWORD_LAST + 16'h0004, 8'h01, EXC_ILLEGAL_ADDR);
    rd(MAPPED_QWORD_LAST, 8'h04);
    repeat (50) @(negedge clk);
    chk(36'(exp_word.size() + exp_exc.size() + exp_ds.size()), 36'h0);
    print_verdict();
  end
endmodule
`default_nettype wire
